// [logic/paged_config_params.svh]
// Register offsets, page codes and field positions of the paged configuration bank
`ifndef PAGED_CONFIG_PARAMS_SVH
`define PAGED_CONFIG_PARAMS_SVH
`define OFS_SOFT_RESET 4'h0
`define OFS_OFFSET_LO 4'h1
`define OFS_OFFSET_HI 4'h2
`define OFS_DIGITAL_LO 4'h3
`define OFS_DIGITAL_HI 4'h4
`define OFS_PAIRING 4'h5
`define ADDR_ANALOG_PAGE 12'h011
`define BIT_RST_HI 7
`define BIT_RST_LO 0
`define BIT_SPLIT 0
`define PAGE_MAIN_DIGITAL 16'h6800
`define PAGE_LINK_DIGITAL 16'h6900
`define PAGE_LINK_ANALOG 16'h6A00
`define PAGE_OFFSET 16'h6100
`define SUBPAGE_OFFSET_READ 16'h0000
`define SUBPAGE_OFFSET_LOAD 16'h0500
`define ANALOG_MASTER 8'h80
`define ANALOG_CONVERTER 8'h0F
`define PREFIX_GENERAL 4'h0
`define PREFIX_DIGITAL_PTR 4'h4
`define PREFIX_DIGITAL_PAGE 4'h6
`define COMMIT_ADDR 12'h000
`define COMMIT_BIT 0
`define REG_RESET_VALUE 8'h00
`endif

// [logic/paged_config_pkg.sv]
// Types shared by the paged configuration bank
package paged_config_pkg;
   typedef enum logic [4:0] {
      PAGE_NONE = 5'b00001,
      PAGE_MAIN = 5'b00010,
      PAGE_LINK_DIG = 5'b00100,
      PAGE_LINK_ANA = 5'b01000,
      PAGE_OFFSET = 5'b10000
   } digital_page_t;
endpackage : paged_config_pkg

// [logic/paged_config_register_bank.sv]
// Paged configuration register bank: general registers and page routing
//
// Function
// - Writing one to bit 7 or 0 of register 0 pulses soft reset; bit self-clears.
// - Digital pointer at registers 3/4; 6800h, 6900h, 6A00h pick main, link digital, link analog.
// - Pointer 6100h opens offset pages; secondary pointer 0000h readback, 0500h load.
// - Pairing bit zero writes both channels; one follows the channel-select bit.
// - Register 11h picks analog page: 80h master, 0Fh converter.
// - Main digital page writes commit after host writes 01h then 00h to 6-000h.
// - All general registers reset to zero: no page, channels paired.
`include "paged_config_params.svh"
module paged_config_register_bank
   import paged_config_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [3:0] i_prefix,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_chan_sel,
   output logic [7:0] o_rdata,
   output logic o_soft_reset,
   output logic [15:0] o_digital_page_pointer,
   output logic [15:0] o_offset_page_pointer,
   output logic [7:0] o_analog_page_pointer,
   output logic o_split_channel_programming,
   output digital_page_t o_digital_page,
   output logic o_offset_read_sel,
   output logic o_offset_load_sel,
   output logic o_analog_master_sel,
   output logic o_analog_converter_sel,
   output logic o_page_wr,
   output logic o_analog_wr,
   output logic o_wr_chan_a,
   output logic o_wr_chan_b,
   output logic [ADDR_W-1:0] o_page_addr,
   output logic [7:0] o_page_wdata,
   output logic o_main_commit
);
   logic [15:0] off_ptr_q;
   logic [15:0] dig_ptr_q;
   logic [7:0] ana_ptr_q;
   logic split_q;
   logic soft_rst_q;
   logic commit_arm_q;
   logic commit_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   wire gen_sel = (i_prefix == `PREFIX_GENERAL) || (i_prefix == `PREFIX_DIGITAL_PTR);
   wire gen_wr = i_wr && gen_sel && (i_addr[ADDR_W-1:4] == '0);
   wire ana_ptr_wr = i_wr && (i_prefix == `PREFIX_GENERAL) && (i_addr == `ADDR_ANALOG_PAGE);
   wire wr_rst = gen_wr && (i_addr[3:0] == `OFS_SOFT_RESET);
   wire rst_req = wr_rst && (i_wdata[`BIT_RST_HI] || i_wdata[`BIT_RST_LO]);
   wire dig_wr = i_wr && (i_prefix == `PREFIX_DIGITAL_PAGE);
   wire commit_wr = dig_wr && (o_digital_page == PAGE_MAIN) && (i_addr == `COMMIT_ADDR);
   wire chan_pair = !split_q;

   // page decode from the retained pointers
   always_comb begin
      unique case (dig_ptr_q)
         `PAGE_MAIN_DIGITAL: o_digital_page = PAGE_MAIN;
         `PAGE_LINK_DIGITAL: o_digital_page = PAGE_LINK_DIG;
         `PAGE_LINK_ANALOG: o_digital_page = PAGE_LINK_ANA;
         `PAGE_OFFSET: o_digital_page = PAGE_OFFSET;
         default: o_digital_page = PAGE_NONE;
      endcase
   end

   assign o_offset_read_sel = (o_digital_page == PAGE_OFFSET) && (off_ptr_q == `SUBPAGE_OFFSET_READ);
   assign o_offset_load_sel = (o_digital_page == PAGE_OFFSET) && (off_ptr_q == `SUBPAGE_OFFSET_LOAD);
   assign o_analog_master_sel = (ana_ptr_q == `ANALOG_MASTER);
   assign o_analog_converter_sel = (ana_ptr_q == `ANALOG_CONVERTER);
   assign o_page_wr = dig_wr && (o_digital_page != PAGE_NONE);
   assign o_analog_wr = i_wr && (i_prefix == `PREFIX_GENERAL) && !gen_wr && !ana_ptr_wr
      && (o_analog_master_sel || o_analog_converter_sel);
   assign o_wr_chan_a = chan_pair || !i_chan_sel;
   assign o_wr_chan_b = chan_pair || i_chan_sel;
   assign o_page_addr = i_addr;
   assign o_page_wdata = i_wdata;
   assign o_soft_reset = soft_rst_q;
   assign o_main_commit = commit_q;
   assign o_digital_page_pointer = dig_ptr_q;
   assign o_offset_page_pointer = off_ptr_q;
   assign o_analog_page_pointer = ana_ptr_q;
   assign o_split_channel_programming = split_q;
   assign o_rdata = rdata_q;

   always_comb begin
      rdata_d = `REG_RESET_VALUE;
      if (i_rd && gen_sel && (i_addr[ADDR_W-1:4] == '0)) begin
         unique case (i_addr[3:0])
            `OFS_OFFSET_LO: rdata_d = off_ptr_q[7:0];
            `OFS_OFFSET_HI: rdata_d = off_ptr_q[15:8];
            `OFS_DIGITAL_LO: rdata_d = dig_ptr_q[7:0];
            `OFS_DIGITAL_HI: rdata_d = dig_ptr_q[15:8];
            `OFS_PAIRING: rdata_d = {7'h00, split_q};
            default: rdata_d = 8'h00;
         endcase
      end else if (i_rd && (i_prefix == `PREFIX_GENERAL) && (i_addr == `ADDR_ANALOG_PAGE)) begin
         rdata_d = ana_ptr_q;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         off_ptr_q <= {`REG_RESET_VALUE, `REG_RESET_VALUE};
         dig_ptr_q <= {`REG_RESET_VALUE, `REG_RESET_VALUE};
         ana_ptr_q <= `REG_RESET_VALUE;
         split_q <= 1'b0;
         soft_rst_q <= 1'b0;
         commit_arm_q <= 1'b0;
         commit_q <= 1'b0;
         rdata_q <= `REG_RESET_VALUE;
      end else begin
         soft_rst_q <= rst_req;
         rdata_q <= rdata_d;
         // pointers change only on their own writes
         if (gen_wr && i_addr[3:0] == `OFS_OFFSET_LO) off_ptr_q[7:0] <= i_wdata;
         if (gen_wr && i_addr[3:0] == `OFS_OFFSET_HI) off_ptr_q[15:8] <= i_wdata;
         if (gen_wr && i_addr[3:0] == `OFS_DIGITAL_LO) dig_ptr_q[7:0] <= i_wdata;
         if (gen_wr && i_addr[3:0] == `OFS_DIGITAL_HI) dig_ptr_q[15:8] <= i_wdata;
         if (gen_wr && i_addr[3:0] == `OFS_PAIRING) split_q <= i_wdata[`BIT_SPLIT];
         if (ana_ptr_wr) ana_ptr_q <= i_wdata;
         // commit fires on the 1 then 0 sequence
         commit_q <= 1'b0;
         if (commit_wr) begin
            commit_arm_q <= i_wdata[`COMMIT_BIT];
            commit_q <= commit_arm_q && !i_wdata[`COMMIT_BIT];
         end
      end
   end

   // Soft reset and commit pulses
   a_soft_reset_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
      rst_req |=> o_soft_reset ##1 (!o_soft_reset || $past(rst_req)))
      else $error("soft reset not a pulse");
   a_soft_reset_src: assert property (@(posedge i_clk) disable iff (i_rst)
      o_soft_reset |-> $past(rst_req))
      else $error("soft reset without request");
   a_commit_seq: assert property (@(posedge i_clk) disable iff (i_rst)
      o_main_commit |-> $past(commit_wr) && !$past(i_wdata[`COMMIT_BIT]))
      else $error("commit without 00h");
   a_commit_single: assert property (@(posedge i_clk) disable iff (i_rst)
      o_main_commit |=> !o_main_commit)
      else $error("commit longer than one cycle");
   a_commit_main_only: assert property (@(posedge i_clk) disable iff (i_rst)
      o_main_commit |-> $past(o_digital_page == PAGE_MAIN))
      else $error("commit outside main page");

   // Page decode
   a_page_main_dec: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_digital_page_pointer == `PAGE_MAIN_DIGITAL) |-> (o_digital_page == PAGE_MAIN))
      else $error("main page decode");
   a_page_link_dig: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_digital_page_pointer == `PAGE_LINK_DIGITAL) |-> (o_digital_page == PAGE_LINK_DIG))
      else $error("link digital page decode");
   a_page_link_ana: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_digital_page_pointer == `PAGE_LINK_ANALOG) |-> (o_digital_page == PAGE_LINK_ANA))
      else $error("link analog page decode");
   a_page_offset_dec: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_digital_page_pointer == `PAGE_OFFSET) |-> (o_digital_page == PAGE_OFFSET))
      else $error("offset page decode");
   a_offset_load_dec: assert property (@(posedge i_clk) disable iff (i_rst)
      o_offset_load_sel |-> (o_digital_page_pointer == `PAGE_OFFSET && o_offset_page_pointer == `SUBPAGE_OFFSET_LOAD))
      else $error("offset load decode");
   a_offset_read_dec: assert property (@(posedge i_clk) disable iff (i_rst)
      o_offset_read_sel |-> (o_digital_page_pointer == `PAGE_OFFSET && o_offset_page_pointer == `SUBPAGE_OFFSET_READ))
      else $error("offset read decode");
   a_analog_master: assert property (@(posedge i_clk) disable iff (i_rst)
      ana_ptr_wr && i_wdata == `ANALOG_MASTER |=> o_analog_master_sel)
      else $error("master page");
   a_analog_conv: assert property (@(posedge i_clk) disable iff (i_rst)
      ana_ptr_wr && i_wdata == `ANALOG_CONVERTER |=> o_analog_converter_sel)
      else $error("converter page");
   a_analog_wr_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      o_analog_wr |-> (o_analog_master_sel || o_analog_converter_sel))
      else $error("analog write with no page");

   // Channel pairing and page writes
   a_pair_both_chan: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_split_channel_programming |-> (o_wr_chan_a && o_wr_chan_b))
      else $error("pair write");
   a_split_one_chan: assert property (@(posedge i_clk) disable iff (i_rst)
      o_split_channel_programming |-> (o_wr_chan_a != o_wr_chan_b))
      else $error("split write");
   a_split_chan_sel: assert property (@(posedge i_clk) disable iff (i_rst)
      o_split_channel_programming && i_chan_sel |-> (o_wr_chan_b && !o_wr_chan_a))
      else $error("split write ignores channel select");
   a_page_wr_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      o_page_wr |-> (i_prefix == `PREFIX_DIGITAL_PAGE && o_digital_page != PAGE_NONE))
      else $error("page write with no page");
   a_dig_hi_load: assert property (@(posedge i_clk) disable iff (i_rst)
      gen_wr && i_addr[3:0] == `OFS_DIGITAL_HI |=> o_digital_page_pointer[15:8] == $past(i_wdata))
      else $error("pointer high byte not loaded");

   // Reset values and pointer retention
   a_reset_zero: assert property (@(posedge i_clk)
      $past(i_rst) |-> (o_digital_page_pointer == '0 && !o_split_channel_programming && o_analog_page_pointer == '0))
      else $error("reset value");
   a_reset_clear: assert property (@(posedge i_clk)
      $past(i_rst) |-> (o_offset_page_pointer == '0 && !o_soft_reset && !o_main_commit && o_rdata == '0))
      else $error("reset clear");
   a_ptr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !(gen_wr && i_addr[3:0] == `OFS_DIGITAL_LO) |=> $stable(o_digital_page_pointer[7:0]))
      else $error("pointer moved");
   a_dig_hi_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !(gen_wr && i_addr[3:0] == `OFS_DIGITAL_HI) |=> $stable(o_digital_page_pointer[15:8]))
      else $error("pointer high byte moved");
   a_off_ptr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !(gen_wr && (i_addr[3:0] == `OFS_OFFSET_LO || i_addr[3:0] == `OFS_OFFSET_HI)) |=> $stable(o_offset_page_pointer))
      else $error("offset pointer moved");
   a_ana_ptr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !ana_ptr_wr |=> $stable(o_analog_page_pointer))
      else $error("analog pointer moved");
   a_split_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !(gen_wr && i_addr[3:0] == `OFS_PAIRING) |=> $stable(o_split_channel_programming))
      else $error("pairing bit moved");
endmodule : paged_config_register_bank

// [testbench/cfg_host_model.sv]
// Host model issuing configuration register writes and reads
module cfg_host_model (
   input wire logic i_clk,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [3:0] o_prefix = 4'h0,
   output logic [11:0] o_addr = 12'h000,
   output logic [7:0] o_wdata = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // One-cycle strobe; released address and data show the inverse of the last value, prefix holds
   task automatic access(input logic w, input logic [3:0] p, input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= w;
      o_rd <= !w;
      o_prefix <= p;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : access
endmodule : cfg_host_model

// [testbench/tb_paged_config_register_bank.sv]
// Self-checking bench for the paged configuration register bank
module tb_paged_config_register_bank;
   timeunit 1ns;
   timeprecision 1ns;
   import paged_config_pkg::*;
   logic i_clk = 1'b0, i_rst = 1'b1, cs = 1'b0;
   logic wr, rd, srst, split, ord, old, am, ac, commit, ca, cb;
   logic pw, aw;
   logic [11:0] paddr;
   logic [7:0] pwdat;
   logic [1:0] pw_q;
   logic [19:0] pa_q;
   logic [3:0] pfx;
   logic [11:0] addr;
   logic [7:0] wd, rdata, aptr;
   logic [15:0] dptr, optr;
   digital_page_t page;
   int n_fail = 0, comparisons = 0;
   // Rows: expected page and analog strobes, prefix, address, data, then channel select and expected status
   logic [43:0] t [33] = '{44'h04004680418, 44'h26000010418, 44'h26000000419, 44'h04004690818, 44'h040046A1018,
      44'h04004612118, 44'h00002052098, 44'h000118020D8, 44'h000110F20B8, 44'h000050120B4, 44'h0000501A0AC,
      44'h0000500A0B8, 44'h04003010238,
      44'h00011808258, 44'h10026C08258,
      44'h04004698258, 44'h04003008858, 44'h26001028858, 44'h040046A9058, 44'h26016029058,
      44'h04004688458, 44'h04003008458, 44'h26041128458, 44'h2604D088458, 44'h26072088458,
      44'h26052808458, 44'h26000018458, 44'h26000008459,
      44'h04004698858, 44'h04003008858, 44'h260310A8858, 44'h260320A8858, 44'h26001318858};
   logic [31:0] rb [7] = '{32'h0001A5A5, 32'h00025A5A, 32'h40033C3C, 32'h4004C3C3, 32'h00050101, 32'h0011F0F0,
      32'h0007FF00};
   initial forever #25 i_clk = ~i_clk;
   paged_config_register_bank u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(wr), .i_rd(rd), .i_prefix(pfx),
      .i_addr(addr), .i_wdata(wd), .i_chan_sel(cs), .o_rdata(rdata), .o_soft_reset(srst),
      .o_digital_page_pointer(dptr), .o_offset_page_pointer(optr), .o_analog_page_pointer(aptr),
      .o_split_channel_programming(split), .o_digital_page(page), .o_offset_read_sel(ord),
      .o_offset_load_sel(old), .o_analog_master_sel(am), .o_analog_converter_sel(ac), .o_page_wr(pw),
      .o_analog_wr(aw), .o_wr_chan_a(ca), .o_wr_chan_b(cb), .o_page_addr(paddr), .o_page_wdata(pwdat),
      .o_main_commit(commit));
   cfg_host_model u_host (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_prefix(pfx), .o_addr(addr), .o_wdata(wd));
   // Capture the combinational page outputs at the edge that takes each write
   always @(posedge i_clk) begin
      pw_q <= {pw, aw};
      pa_q <= {paddr, pwdat};
   end
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic print_verdict();
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (1000) @(posedge i_clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      chk("reset pointers", 40'h0, {dptr, optr, aptr});
      chk("reset flags", 40'h61, {split, ca, cb, page});
      foreach (t[i]) begin
         @(posedge i_clk);
         cs <= t[i][15];
         u_host.access(1'b1, t[i][39:36], t[i][35:24], t[i][23:16]);
         #1;
         chk("status", t[i][13:0], {page, ord, old, am, ac, ca, cb, split, srst, commit});
         chk("page strobes", t[i][41:40], pw_q);
         chk("page pass", t[i][35:16], pa_q);
      end
      foreach (rb[i]) begin
         u_host.access(1'b1, rb[i][31:28], rb[i][27:16], rb[i][15:8]);
         u_host.access(1'b0, rb[i][31:28], rb[i][27:16], 8'h00);
         #1;
         chk("readback", rb[i][7:0], rdata);
      end
      for (int i = 0; i < 2; i++) begin
         u_host.access(1'b1, 4'h0, 12'h000, i ? 8'h01 : 8'h80);
         #1;
         chk("soft reset", 40'h1, srst);
         @(posedge i_clk) #1 chk("soft reset end", 40'h0, srst);
      end
      print_verdict();
   end
endmodule : tb_paged_config_register_bank
